// ===== verilog/dcvi_cfg.svh
// constants for the daisy-chain vectored interrupt block
// Overview of operation
// (RULE1) reset leaves the block in direct mode
// (RULE2) only the chain command selects chained mode
// (RULE3) a pending request drives irq_out_n low
// (RULE4) host answers a request with acknowledge
// (RULE5) chained acknowledge puts vector on data bus
// (RULE6) chain pins act only in chained mode
// (RULE7) chain input high lets unmasked sources request
// (RULE8) masked sources stay off despite chain input
// (RULE9) chain input low suppresses every request
// (RULE10) chain out high: in high, idle, serviced
// (RULE11) own request pulls chain output low
// (RULE12) chain out low until clear-in-service command
// (RULE13) host ends each service with clear command
// (RULE14) request released once all causes cleared
// (RULE15) acknowledge marks next cycle as vector cycle
// (RULE16) vector driven only when requesting and enabled
`ifndef DCVI_CFG_SVH
`define DCVI_CFG_SVH

`define DCVI_DATA_W       8
`define DCVI_ADDR_W       4
`define DCVI_NUM_SRC      8

`define DCVI_OFS_VECTOR   4'h0
`define DCVI_OFS_MASK     4'h1
`define DCVI_OFS_STATUS   4'h2
`define DCVI_OFS_CONTROL  4'h3

`define DCVI_VECTOR_RST   8'h0f
`define DCVI_MASK_RST     8'h00
`define DCVI_STATUS_RST   8'h00
`define DCVI_ZERO_BYTE    8'h00

`define DCVI_CMD_CHAINED  0
`define DCVI_CMD_CLR_IUS  1

`define DCVI_ST_CHAINED   0
`define DCVI_ST_IUS       1
`define DCVI_ST_REQ       2
`define DCVI_ST_CEO       3

`endif

// ===== verilog/dcvi_pkg.sv
// types shared by the daisy-chain vectored interrupt block
package dcvi_pkg;
   typedef logic [7:0] dcvi_byte_t;
   typedef logic [3:0] dcvi_addr_t;
   typedef enum logic [0:0]
   {
      DCVI_MODE_DIRECT  = 1'b0,
      DCVI_MODE_CHAINED = 1'b1
   } dcvi_mode_t;
endpackage : dcvi_pkg

// ===== verilog/dcvi_ctrl.sv
// request, acknowledge and priority chain logic of the interrupt block
`timescale 1ns/1ps
`include "dcvi_cfg.svh"

module dcvi_ctrl
(
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic               clk_en,
   input  wire dcvi_pkg::dcvi_addr_t reg_addr,
   input  wire dcvi_pkg::dcvi_byte_t reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output      dcvi_pkg::dcvi_byte_t reg_rdata,
   input  wire dcvi_pkg::dcvi_byte_t src_event,
   output      logic               irq_out_n,
   input  wire logic               host_ack_n,
   input  wire logic               chain_enable_in,
   output      logic               chain_enable_out,
   output      dcvi_pkg::dcvi_byte_t data_out,
   output      logic               data_oe
);
   import dcvi_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // decode

   function automatic logic hit(input dcvi_addr_t a, input dcvi_addr_t ofs);
      hit = (a == ofs);
   endfunction : hit

   logic       wr_vector;
   logic       wr_mask;
   logic       wr_status;
   logic       wr_control;
   logic       cmd_chain;
   logic       cmd_clr_ius;

   assign wr_vector   = reg_wr && hit(reg_addr, `DCVI_OFS_VECTOR);
   assign wr_mask     = reg_wr && hit(reg_addr, `DCVI_OFS_MASK);
   assign wr_status   = reg_wr && hit(reg_addr, `DCVI_OFS_STATUS);
   assign wr_control  = reg_wr && hit(reg_addr, `DCVI_OFS_CONTROL);
   assign cmd_chain   = wr_control && reg_wdata[`DCVI_CMD_CHAINED];
   assign cmd_clr_ius = wr_control && reg_wdata[`DCVI_CMD_CLR_IUS];

   ////////////////////////////////////////////////////////////////////////////////
   // registers and pending sources

   dcvi_byte_t vector_r;
   dcvi_byte_t vector_nxt;
   dcvi_byte_t mask_r;
   dcvi_byte_t mask_nxt;
   dcvi_byte_t pending_r;
   dcvi_byte_t pending_nxt;
   dcvi_mode_t mode_r;
   dcvi_mode_t mode_nxt;
   logic       chained;

   assign chained = (mode_r == DCVI_MODE_CHAINED);

   // a source event in the same cycle as its clear keeps the bit set
   genvar gi;
   generate
      for (gi = 0; gi < `DCVI_NUM_SRC; gi++)
      begin : g_pend
         assign pending_nxt[gi] = src_event[gi] ||
                                  (pending_r[gi] && !(wr_status && reg_wdata[gi]));
      end
   endgenerate

   always_comb
   begin
      vector_nxt = wr_vector ? reg_wdata : vector_r;
      mask_nxt   = wr_mask   ? reg_wdata : mask_r;
      mode_nxt   = mode_r;
      if (cmd_chain)
      begin
         mode_nxt = DCVI_MODE_CHAINED;            // see RULE2
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         vector_r  <= `DCVI_VECTOR_RST;
         mask_r    <= `DCVI_MASK_RST;
         pending_r <= `DCVI_STATUS_RST;
         mode_r    <= DCVI_MODE_DIRECT;           // see RULE1
      end
      else if (clk_en)
      begin
         vector_r  <= vector_nxt;
         mask_r    <= mask_nxt;
         pending_r <= pending_nxt;
         mode_r    <= mode_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // request, acknowledge and chain

   logic       req_c;
   logic       ack_fall;
   logic       ack_take;
   logic       ack_prev_r;
   logic       ack_prev_nxt;
   logic       ius_r;
   logic       ius_nxt;
   logic       irq_n_r;
   logic       irq_n_nxt;
   logic       ceo_r;
   logic       ceo_nxt;
   logic       oe_r;
   logic       oe_nxt;
   dcvi_byte_t dout_r;
   dcvi_byte_t dout_nxt;
   dcvi_byte_t rdata_r;
   dcvi_byte_t rdata_nxt;

   // unmasked pending sources request; chain input gates them only when chained
   assign req_c = (|(pending_r & mask_r)) &&     // see RULE8
                  (!chained || chain_enable_in); // see RULE7 see RULE9

   // acknowledge low announces that the next cycle carries the vector
   assign ack_fall = ack_prev_r && !host_ack_n;  // see RULE15 see RULE4
   assign ack_take = chained && ack_fall && req_c && chain_enable_in; // see RULE16

   always_comb
   begin
      ack_prev_nxt = host_ack_n;
      irq_n_nxt    = !req_c;                     // see RULE3 see RULE14
      ius_nxt      = ius_r;
      if (ack_take)
      begin
         ius_nxt = 1'b1;
      end
      else if (cmd_clr_ius)
      begin
         ius_nxt = 1'b0;                          // see RULE12 see RULE13
      end
      // in direct mode the chain is passed through so lower devices keep working
      if (chained)
      begin
         ceo_nxt = chain_enable_in && !req_c && !ius_r; // see RULE10 see RULE11
      end
      else
      begin
         ceo_nxt = chain_enable_in;              // see RULE6
      end
      // bus released as soon as the acknowledge ends
      oe_nxt   = chained && !host_ack_n && (oe_r || ack_take); // see RULE5
      dout_nxt = oe_nxt ? vector_r : `DCVI_ZERO_BYTE;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ack_prev_r <= 1'b1;
         ius_r      <= 1'b0;
         irq_n_r    <= 1'b1;
         ceo_r      <= 1'b0;
         oe_r       <= 1'b0;
         dout_r     <= `DCVI_ZERO_BYTE;
      end
      else if (clk_en)
      begin
         ack_prev_r <= ack_prev_nxt;
         ius_r      <= ius_nxt;
         irq_n_r    <= irq_n_nxt;
         ceo_r      <= ceo_nxt;
         oe_r       <= oe_nxt;
         dout_r     <= dout_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read port

   always_comb
   begin
      rdata_nxt = `DCVI_ZERO_BYTE;
      if (reg_rd)
      begin
         if (hit(reg_addr, `DCVI_OFS_VECTOR))
         begin
            rdata_nxt = vector_r;
         end
         else if (hit(reg_addr, `DCVI_OFS_MASK))
         begin
            rdata_nxt = mask_r;
         end
         else if (hit(reg_addr, `DCVI_OFS_STATUS))
         begin
            rdata_nxt = pending_r;
         end
         else if (hit(reg_addr, `DCVI_OFS_CONTROL))
         begin
            rdata_nxt[`DCVI_ST_CHAINED] = chained;
            rdata_nxt[`DCVI_ST_IUS]     = ius_r;
            rdata_nxt[`DCVI_ST_REQ]     = req_c;
            rdata_nxt[`DCVI_ST_CEO]     = ceo_r;
         end
         else
         begin
            rdata_nxt = `DCVI_ZERO_BYTE;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_r <= `DCVI_ZERO_BYTE;
      end
      else if (clk_en)
      begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata        = rdata_r;
   assign irq_out_n        = irq_n_r;
   assign chain_enable_out = ceo_r;
   assign data_out         = dout_r;
   assign data_oe          = oe_r;

   ////////////////////////////////////////////////////////////////////////////////
   // assertions; a frozen clock enable counts as no cycle, except in a_reset_direct_mode

   default clocking cb @(posedge core_clk iff clk_en);
   endclocking
   default disable iff (rst);

   // looked at one edge on: before the first reset edge the mode is still unknown
   a_reset_direct_mode: assert property ( // see RULE1
      @(posedge core_clk) disable iff (1'b0) rst |=> (mode_r == DCVI_MODE_DIRECT))
      else $error("mode not direct during reset");

   a_chain_entry_cmd: assert property ( // see RULE2
      $rose(chained) |-> $past(cmd_chain))
      else $error("chained mode entered without command");

   a_irq_follows_req: assert property ( // see RULE3
      req_c |=> !irq_out_n)
      else $error("request not shown on irq_out_n");

   a_vector_on_bus: assert property ( // see RULE5
      ack_take ##1 (!host_ack_n && clk_en) |-> data_oe && data_out == $past(vector_r))
      else $error("vector not driven after acknowledge");

   // the release edge is skipped: the chain output still holds its reset value there
   a_direct_pass_chain: assert property ( // see RULE6
      (!chained && !rst) |=> chain_enable_out == $past(chain_enable_in))
      else $error("chain output not passed through in direct mode");

   a_masked_no_irq: assert property ( // see RULE8
      ((pending_r & mask_r) == `DCVI_ZERO_BYTE) |=> irq_out_n)
      else $error("masked source raised a request");

   a_chain_in_low: assert property ( // see RULE9
      (chained && !chain_enable_in) |=> irq_out_n && !chain_enable_out)
      else $error("request not suppressed by low chain input");

   a_chain_out_cond: assert property ( // see RULE10
      chained |=> chain_enable_out == $past(chain_enable_in && !req_c && !ius_r))
      else $error("chain output condition wrong");

   a_ius_hold_low: assert property ( // see RULE12
      (ius_r && !cmd_clr_ius) |=> ius_r ##0 !chain_enable_out [*2])
      else $error("in-service dropped without clear command");

   a_vector_gated: assert property ( // see RULE16
      $rose(data_oe) |-> $past(req_c && chain_enable_in && chained))
      else $error("vector driven without request or enable");

   a_direct_no_vector: assert property ( // see RULE6
      !chained |=> !data_oe)
      else $error("vector driven in direct mode");

   a_own_req_blocks: assert property ( // see RULE11
      (chained && req_c) |=> !chain_enable_out)
      else $error("chain output high during own request");

   a_ack_sets_service: assert property ( // see RULE12
      ack_take |=> ius_r)
      else $error("in-service not set by acknowledge");

   a_unmasked_request: assert property ( // see RULE7
      (chain_enable_in && ((pending_r & mask_r) != `DCVI_ZERO_BYTE)) |=> !irq_out_n)
      else $error("unmasked source not requesting with chain input high");

   a_bus_release: assert property ( // see RULE16
      host_ack_n |=> !data_oe)
      else $error("bus still driven after acknowledge ended");

   a_irq_released: assert property ( // see RULE14
      !req_c |=> irq_out_n)
      else $error("request output not released");

   c_chain_ack: cover property (chained ##1 ack_take ##1 data_oe);
   c_ius_clear: cover property (ius_r ##1 cmd_clr_ius ##1 !ius_r);
   c_direct_irq: cover property (!chained && req_c ##1 !irq_out_n);
   c_set_beats_clear: cover property (wr_status && (src_event & reg_wdata) != `DCVI_ZERO_BYTE);

endmodule : dcvi_ctrl

// ===== sim/dcvi_host.sv
// host model: answers a pending request with an acknowledge
`timescale 1ns/1ps

module dcvi_host
(
   input  wire logic       core_clk,
   input  wire logic       irq_out_n,
   input  wire logic [3:0] ack_delay,
   output      logic       host_ack_n
);
   logic [3:0] wait_cnt = 4'h0;

   initial host_ack_n = 1'b1;

   // counter saturates so a long wait never releases the acknowledge early
   always @(posedge core_clk)
   begin
      if (irq_out_n)
         wait_cnt <= 4'h0;
      else
         wait_cnt <= wait_cnt + {3'h0, wait_cnt != 4'hf};
      host_ack_n <= irq_out_n | (wait_cnt < ack_delay);
   end
endmodule : dcvi_host

// ===== sim/dcvi_ctrl_tb.sv
// self-checking bench for the daisy-chain interrupt block
`timescale 1ns/1ps
`include "dcvi_cfg.svh"

module dcvi_ctrl_tb;
   import dcvi_pkg::*;
   logic       core_clk = 1'b0;
   logic       rst = 1'b1;
   logic       clk_en = 1'b1;
   dcvi_addr_t reg_addr = '0;
   dcvi_byte_t reg_wdata = '0;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   dcvi_byte_t reg_rdata;
   dcvi_byte_t src_event = '0;
   logic       irq_out_n;
   logic       host_ack_n;
   logic       chain_enable_in = 1'b1;
   logic       chain_enable_out;
   dcvi_byte_t data_out;
   logic       data_oe;
   logic [3:0] ack_delay = 4'h0;
   logic       rd_q = 1'b0;
   logic       oe_q = 1'b0;
   dcvi_byte_t rd_exp_q[$];
   dcvi_byte_t vec_q[$];
   dcvi_byte_t vec;
   dcvi_byte_t bit_m;
   int         bad_count = 0;
   int         total_checks = 0;

   always #12.5 core_clk = ~core_clk;

   dcvi_ctrl i_dcvi_ctrl
   (
      .core_clk         (core_clk),
      .rst              (rst),
      .clk_en           (clk_en),
      .reg_addr         (reg_addr),
      .reg_wdata        (reg_wdata),
      .reg_wr           (reg_wr),
      .reg_rd           (reg_rd),
      .reg_rdata        (reg_rdata),
      .src_event        (src_event),
      .irq_out_n        (irq_out_n),
      .host_ack_n       (host_ack_n),
      .chain_enable_in  (chain_enable_in),
      .chain_enable_out (chain_enable_out),
      .data_out         (data_out),
      .data_oe          (data_oe)
   );

   dcvi_host i_dcvi_host
   (
      .core_clk   (core_clk),
      .irq_out_n  (irq_out_n),
      .ack_delay  (ack_delay),
      .host_ack_n (host_ack_n)
   );

   ////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   task automatic chk(input string n, input dcvi_byte_t e, input dcvi_byte_t g);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic pins(input logic irq_e, input logic ceo_e);
      chk("irq_out_n", {7'h0, irq_e}, {7'h0, irq_out_n});
      chk("chain_enable_out", {7'h0, ceo_e}, {7'h0, chain_enable_out});
   endtask : pins

   task automatic wr(input dcvi_addr_t a, input dcvi_byte_t d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      cyc(1);
      reg_wr <= 1'b0;
      cyc(1);
   endtask : wr

   task automatic rd(input dcvi_addr_t a, input dcvi_byte_t e);
      rd_exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      cyc(1);
      reg_rd <= 1'b0;
      cyc(1);
   endtask : rd

   // pending bit lands one edge after the pulse, the request one edge later
   task automatic pulse(input dcvi_byte_t b);
      src_event <= b;
      cyc(1);
      src_event <= '0;
      cyc(2);
   endtask : pulse

   task automatic tally_and_finish();
      if (bad_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   // result watcher: read data and acknowledge vectors against queued notes
   always @(posedge core_clk)
   begin
      if (rd_q)
         chk("reg_rdata", rd_exp_q.pop_front(), reg_rdata);
      if (data_oe === 1'b1 && !oe_q)
      begin
         if (vec_q.size() == 0)
            chk("data_oe", 8'h00, 8'h01);
         else
            chk("data_out", vec_q.pop_front(), data_out);
      end
      rd_q <= reg_rd;
      oe_q <= data_oe;
   end

   initial
   begin
      cyc(3000);
      bad_count++;
      tally_and_finish();
   end

   initial
   begin
      void'($urandom(32'h6ec0));
      cyc(8);
      rst <= 1'b0;
      cyc(1);
      rd(`DCVI_OFS_VECTOR, `DCVI_VECTOR_RST);
      rd(`DCVI_OFS_MASK, `DCVI_MASK_RST);
      rd(`DCVI_OFS_CONTROL, 8'h08);
      wr(4'h7, 8'hff);
      rd(4'h7, 8'h00);
      // direct mode: a low chain input must not hold the request back
      bit_m = 8'h01 << $urandom_range(7);
      chain_enable_in <= 1'b0;
      wr(`DCVI_OFS_MASK, 8'hff);
      pulse(bit_m);
      pins(1'b0, 1'b0);
      cyc(8);
      chk("data_oe", 8'h00, {7'h0, data_oe});
      wr(`DCVI_OFS_STATUS, bit_m);
      cyc(1);
      pins(1'b1, 1'b0);
      chain_enable_in <= 1'b1;
      wr(`DCVI_OFS_CONTROL, 8'h01);
      rd(`DCVI_OFS_CONTROL, 8'h09);
      for (int i = 0; i < 8; i++)
      begin
         bit_m = 8'h01 << i;
         vec = dcvi_byte_t'($urandom);
         ack_delay <= 4'($urandom_range(7));
         wr(`DCVI_OFS_VECTOR, vec);
         wr(`DCVI_OFS_MASK, ~bit_m);
         pulse(bit_m);
         pins(1'b1, 1'b1);
         chain_enable_in <= 1'b0;
         wr(`DCVI_OFS_MASK, 8'hff);
         cyc(1);
         pins(1'b1, 1'b0);
         vec_q.push_back(vec);
         chain_enable_in <= 1'b1;
         cyc(2);
         pins(1'b0, 1'b0);
         repeat (20) if (data_oe !== 1'b1) cyc(1);
         chk("data_oe", 8'h01, {7'h0, data_oe});
         rd(`DCVI_OFS_CONTROL, 8'h07);
         rd(`DCVI_OFS_STATUS, bit_m);
         wr(`DCVI_OFS_STATUS, bit_m);
         cyc(1);
         pins(1'b1, 1'b0);
         wr(`DCVI_OFS_CONTROL, 8'h02);
         cyc(2);
         pins(1'b1, 1'b1);
      end
      chk("vectors_left", 8'h00, 8'(vec_q.size()));
      // acknowledge arrives in the same cycle as the chain input drops: no vector may follow
      ack_delay <= 4'h0;
      pulse(8'h01);
      chain_enable_in <= 1'b0;
      cyc(4);
      chk("data_oe", 8'h00, {7'h0, data_oe});
      pins(1'b1, 1'b0);
      // a source event beside its clear, still high on the edge after, keeps the pending bit
      src_event <= 8'h01;
      wr(`DCVI_OFS_STATUS, 8'h01);
      src_event <= '0;
      rd(`DCVI_OFS_STATUS, 8'h01);
      wr(`DCVI_OFS_STATUS, 8'h01);
      rd(`DCVI_OFS_STATUS, 8'h00);
      // a frozen clock enable must not catch a source event
      clk_en <= 1'b0;
      src_event <= 8'h02;
      cyc(1);
      clk_en <= 1'b1;
      src_event <= '0;
      rd(`DCVI_OFS_STATUS, 8'h00);
      // reset in mid-run must fall back to direct mode
      chain_enable_in <= 1'b1;
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(1);
      rd(`DCVI_OFS_CONTROL, 8'h08);
      rd(`DCVI_OFS_VECTOR, `DCVI_VECTOR_RST);
      tally_and_finish();
   end
endmodule : dcvi_ctrl_tb
